// *** axo_map.svh ***
// Constant map for the accumulator / X register operation block.
// Assumes inclusion by bare name from the package, the divider and the core.
`ifndef AXO_MAP_SVH
`define AXO_MAP_SVH
`define AXO_OP_STOP 8'h1c
`define AXO_OP_ACCU_XREG_ACCU_IMMEDIATE_INSTR_A_INSTR 8'h21
`define AXO_OP_ACCU_AXIS 8'h22
`define AXO_OP_ACCU_GLOBAL 8'h23
`define AXO_OP_PROG_RESET 8'h83
`define AXO_T_ADD 8'h00
`define AXO_T_SUB 8'h01
`define AXO_T_MUL 8'h02
`define AXO_T_DIV 8'h03
`define AXO_T_MOD 8'h04
`define AXO_T_AND 8'h05
`define AXO_T_OR 8'h06
`define AXO_T_XOR 8'h07
`define AXO_T_NOT 8'h08
`define AXO_T_LOAD 8'h09
`define AXO_T_SWAP 8'h0a
`define AXO_AP_TARGET_POS 8'h00
`define AXO_BANK_0 8'h00
`define AXO_BANK_USER 8'h02
`define AXO_BANK_3 8'h03
`define AXO_ST_OK 8'h64
`define AXO_ST_BAD_TYPE 8'h03
`define AXO_ST_BAD_VALUE 8'h04
`define AXO_ST_BAD_OP 8'h02
`define AXO_DIV_CYCLES 6'h20
`define AXO_ZERO32 32'h00000000
`endif

// *** axo_pkg.sv ***
// Types for the accumulator / X register operation block.
// Assumes axo_map.svh is on the include path.
`default_nettype none
`include "axo_map.svh"
package axo_pkg;
  // One decoded command frame, value sent MSB first
  typedef struct packed {
    logic [7:0] instr;
    logic [7:0] opType;
    logic [7:0] motorBank;
    logic [31:0] value;
  } axo_cmd_t;
  // Direct-mode reply
  typedef struct packed {
    logic [7:0] status;
    logic [31:0] value;
  } axo_reply_t;
  // Parameter write toward the parameter tables
  typedef struct packed {
    logic isGlobal;
    logic [7:0] paramNum;
    logic [7:0] motorBank;
    logic [31:0] data;
  } axo_pwrite_t;
  typedef enum logic [3:0] {
    AXO_IDLE = 4'b0001,
    AXO_DIVIDE = 4'b0010,
    AXO_REPLY = 4'b0100,
    AXO_SPARE = 4'b1000
  } axo_state_t;
endpackage : axo_pkg
`default_nettype wire

// *** axo_divider.sv ***
// Iterative signed 32-bit divider, one quotient bit per clock.
// Assumes start is only pulsed while idle; divisor nonzero.
`timescale 1ns/1ps
`default_nettype none
`include "axo_map.svh"
module axo_divider
  import axo_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic [31:0] dividend,
  input wire logic [31:0] divisor,
  output logic done,
  output logic [31:0] quotient,
  output logic [31:0] remainder
);
  logic [31:0] remQ, remD, quoQ, quoD, divQ;
  logic [5:0] cntQ;
  logic negQ, negRemQ, busyQ;
  wire [31:0] absDividend = dividend[31] ? 32'h0 - dividend : dividend;
  wire [31:0] absDivisor = divisor[31] ? 32'h0 - divisor : divisor;
  wire [32:0] trial = {remQ, quoQ[31]} - {1'b0, divQ};
  // Restoring step
  always_comb begin
    if (!trial[32]) begin
      remD = trial[31:0];
      quoD = {quoQ[30:0], 1'b1};
    end else begin
      remD = {remQ[30:0], quoQ[31]};
      quoD = {quoQ[30:0], 1'b0};
    end
  end
  // Results truncate toward zero; remainder takes dividend's sign
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      remQ <= `AXO_ZERO32;
      quoQ <= `AXO_ZERO32;
      divQ <= `AXO_ZERO32;
      cntQ <= 6'h00;
      negQ <= 1'b0;
      negRemQ <= 1'b0;
      busyQ <= 1'b0;
      done <= 1'b0;
      quotient <= `AXO_ZERO32;
      remainder <= `AXO_ZERO32;
    end else begin
      done <= 1'b0;
      if (start) begin
        remQ <= `AXO_ZERO32;
        quoQ <= absDividend;
        divQ <= absDivisor;
        cntQ <= `AXO_DIV_CYCLES;
        negQ <= dividend[31] ^ divisor[31];
        negRemQ <= dividend[31];
        busyQ <= 1'b1;
      end else if (busyQ) begin
        remQ <= remD;
        quoQ <= quoD;
        cntQ <= cntQ - 6'h01;
        if (cntQ == 6'h01) begin
          busyQ <= 1'b0;
          done <= 1'b1;
          quotient <= negQ ? 32'h0 - quoD : quoD;
          remainder <= negRemQ ? 32'h0 - remD : remD;
        end
      end
    end
  end
endmodule : axo_divider
`default_nettype wire

// *** axo_core.sv ***
// Executes halt, accumulator/X arithmetic and accumulator-to-parameter
// commands. Assumes frames arrive decoded and checksum-checked.
//
// Operation
// RQ1: Code 28 halts the standalone program; other fields ignored.
// RQ2: Code 33 uses X as second operand, result into accumulator.
// RQ3: Type 0 adds, 1 subtracts, 2 multiplies accumulator by X.
// RQ4: Type 3 divides accumulator by X, type 4 leaves remainder.
// RQ5: Types 5, 6, 7 are bitwise AND, OR, XOR into accumulator.
// RQ6: Type 8 inverts the X register bitwise.
// RQ7: Type 9 copies accumulator into X.
// RQ8: Type 10 swaps accumulator and X in one step.
// RQ9: Host requests multiply as instruction 21h, type 02h, zeros.
// RQ10: Code 34 writes accumulator to axis parameter type of motor.
// RQ11: Axis parameter 0 write updates that motor's target position.
// RQ12: Axis write operands: parameter number then motor number.
// RQ13: Global write stores accumulator at parameter number and bank.
// RQ14: Global write is code 35; banks 0, 2, 3; bank 2 user vars.
// RQ15: Program reset stops, clears PC, SP, accumulator, X, flags.
// RQ16: Accumulator and X are 32-bit signed, value sent MSB first.
`timescale 1ns/1ps
`default_nettype none
`include "axo_map.svh"
module axo_core
  import axo_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic cmdValid,
  input wire axo_cmd_t cmd,
  input wire logic accuLoad,
  input wire logic [31:0] accuLoadValue,
  input wire logic progRunning,
  output logic cmdReady,
  output logic replyValid,
  output axo_reply_t reply,
  output logic progHalt,
  output logic progReset,
  output logic paramWrite,
  output axo_pwrite_t param,
  output logic targetPosWrite,
  output logic [7:0] targetPosMotor,
  output logic [31:0] targetPos,
  output logic [31:0] accu,
  output logic [31:0] xReg
);
  axo_state_t stateQ, stateD;
  logic [31:0] accuD, xD;
  logic [7:0] statusD;
  logic divStart, divDone, keepRem_q;
  logic [31:0] divQuo, divRem;

  // Decode of the incoming frame
  // Ready gates the take too, so nothing slips in at reset release
  wire take = cmdValid && cmdReady && (stateQ == AXO_IDLE);
  wire isStop = cmd.instr == `AXO_OP_STOP;
  wire isCalcx = cmd.instr == `AXO_OP_ACCU_XREG_ACCU_IMMEDIATE_INSTR_A_INSTR;
  wire isAxis = cmd.instr == `AXO_OP_ACCU_AXIS;
  wire isGlobal = cmd.instr == `AXO_OP_ACCU_GLOBAL;
  wire isReset = cmd.instr == `AXO_OP_PROG_RESET;
  wire isDivType = (cmd.opType == `AXO_T_DIV) || (cmd.opType == `AXO_T_MOD);
  wire divByZero = isDivType && (xReg == `AXO_ZERO32);
  wire bankOk = (cmd.motorBank == `AXO_BANK_0) ||
                (cmd.motorBank == `AXO_BANK_USER) ||
                (cmd.motorBank == `AXO_BANK_3); // [RQ14]
  // Signed product, low word kept as a 32-bit accumulator would
  wire signed [63:0] prod = $signed(accu) * $signed(xReg); // [RQ3] [RQ16]

  // Arithmetic result of one ACCU_XREG_ACCU_IMMEDIATE_INSTR_A_INSTR-style operation
  function automatic logic [31:0] calcResult(input logic [7:0] t,
                                             input logic [31:0] a,
                                             input logic [31:0] x,
                                             input logic [31:0] p);
    case (t)
      `AXO_T_ADD: calcResult = a + x; // [RQ3]
      `AXO_T_SUB: calcResult = a - x; // [RQ3]
      `AXO_T_MUL: calcResult = p; // [RQ3]
      `AXO_T_AND: calcResult = a & x; // [RQ5]
      `AXO_T_OR: calcResult = a | x; // [RQ5]
      `AXO_T_XOR: calcResult = a ^ x; // [RQ5]
      `AXO_T_SWAP: calcResult = x; // [RQ8]
      default: calcResult = a;
    endcase
  endfunction : calcResult

  wire typeKnown = cmd.opType <= `AXO_T_SWAP;

  // Next state, accumulator, X and status
  always_comb begin
    stateD = stateQ;
    accuD = accu;
    xD = xReg;
    statusD = `AXO_ST_OK;
    divStart = 1'b0;
    case (stateQ)
      AXO_IDLE: begin
        if (take) begin
          stateD = AXO_REPLY;
          if (isReset) begin
            accuD = `AXO_ZERO32; // [RQ15]
            xD = `AXO_ZERO32; // [RQ15]
          end else if (isCalcx) begin
            if (!typeKnown) begin
              statusD = `AXO_ST_BAD_TYPE;
            end else if (divByZero) begin
              // Divide by zero leaves both registers untouched
              statusD = `AXO_ST_BAD_VALUE;
            end else if (isDivType) begin
              divStart = 1'b1; // [RQ4]
              stateD = AXO_DIVIDE;
            end else begin
              accuD = calcResult(cmd.opType, accu, xReg, prod[31:0]); // [RQ2]
              if (cmd.opType == `AXO_T_NOT) begin
                xD = ~xReg; // [RQ6]
              end
              if (cmd.opType == `AXO_T_LOAD) begin
                xD = accu; // [RQ7]
              end
              if (cmd.opType == `AXO_T_SWAP) begin
                xD = accu; // [RQ8]
              end
            end
          end else if (isGlobal && !bankOk) begin
            statusD = `AXO_ST_BAD_VALUE;
          end else if (!(isStop || isAxis || isGlobal)) begin
            statusD = `AXO_ST_BAD_OP;
          end
        end else if (accuLoad) begin
          accuD = accuLoadValue;
        end
      end
      AXO_DIVIDE: begin
        if (divDone) begin
          accuD = keepRem_q ? divRem : divQuo; // [RQ4]
          stateD = AXO_REPLY;
        end
      end
      AXO_REPLY: stateD = AXO_IDLE;
      default: stateD = AXO_IDLE;
    endcase
  end

  // Command processing registers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      stateQ <= AXO_IDLE;
      accu <= `AXO_ZERO32;
      xReg <= `AXO_ZERO32;
      keepRem_q <= 1'b0;
      reply <= '0;
    end else begin
      stateQ <= stateD;
      accu <= accuD;
      xReg <= xD;
      if (divStart) begin
        keepRem_q <= cmd.opType == `AXO_T_MOD;
      end
      if (take) begin
        reply <= '{status: statusD, value: `AXO_ZERO32};
      end
    end
  end

  // Handshake outputs, and one-cycle strobes toward program control and parameter tables
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cmdReady <= 1'b0;
      replyValid <= 1'b0;
      progHalt <= 1'b0;
      progReset <= 1'b0;
      paramWrite <= 1'b0;
      param <= '0;
      targetPosWrite <= 1'b0;
      targetPosMotor <= 8'h00;
      targetPos <= `AXO_ZERO32;
    end else begin
      cmdReady <= stateD == AXO_IDLE;
      replyValid <= stateD == AXO_REPLY;
      progHalt <= take && isStop && progRunning; // [RQ1]
      progReset <= take && isReset; // [RQ15]
      paramWrite <= take && (isAxis || (isGlobal && bankOk)); // [RQ10] [RQ13]
      targetPosWrite <= take && isAxis &&
                        cmd.opType == `AXO_AP_TARGET_POS; // [RQ11]
      if (take && (isAxis || isGlobal)) begin
        // Type field is the parameter, motor/bank the axis or bank
        param <= '{isGlobal: isGlobal, paramNum: cmd.opType,
                   motorBank: cmd.motorBank, data: accu}; // [RQ12] [RQ13]
        targetPosMotor <= cmd.motorBank; // [RQ11]
        targetPos <= accu; // [RQ11]
      end
    end
  end

  // Division takes many cycles; the reply waits on it
  axo_divider u_div (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .start(divStart),
    .dividend(accu),
    .divisor(xReg),
    .done(divDone),
    .quotient(divQuo),
    .remainder(divRem)
  );
endmodule : axo_core
`default_nettype wire

// *** axo_core_props.sv ***
// Concurrent checks on the accumulator / X register operation block.
// Assumes bind into axo_core; one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module axo_core_props
  import axo_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic cmdValid,
  input wire logic cmdReady,
  input wire axo_cmd_t cmd,
  input wire logic progRunning,
  input wire logic progHalt,
  input wire logic progReset,
  input wire logic paramWrite,
  input wire axo_pwrite_t param,
  input wire logic [31:0] accu,
  input wire logic [31:0] xReg
);
  // Frame taken at this edge, and the operation decodes
  wire tk = cmdValid && cmdReady;
  wire cx = tk && cmd.instr == 8'h21;
  wire [7:0] ty = cmd.opType;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  xor_accu_a:
    assert property (cx && ty == 8'h07 |=> accu == ($past(accu) ^ $past(xReg)))
      else $error("xor result wrong");
  invert_x_a:
    assert property (cx && ty == 8'h08 |=> xReg == ~$past(xReg)
      && $stable(accu))
      else $error("invert result wrong");
  load_x_a:
    assert property (cx && ty == 8'h09 |=> xReg == $past(accu))
      else $error("load result wrong");
  swap_regs_a:
    assert property (cx && ty == 8'h0a |=> accu == $past(xReg)
      && xReg == $past(accu))
      else $error("swap result wrong");
  halt_prog_a:
    assert property (tk && cmd.instr == 8'h1c && progRunning |=> progHalt)
      else $error("no halt pulse");
  axis_write_a:
    assert property (tk && cmd.instr == 8'h22 |=> paramWrite && !param.isGlobal
      && param.data == $past(accu) && param.paramNum == $past(ty))
      else $error("axis write wrong");
  global_write_a:
    assert property (tk && cmd.instr == 8'h23 && cmd.motorBank == 8'h02
      |=> paramWrite && param.isGlobal && param.data == $past(accu))
      else $error("global write wrong");
  prog_reset_a:
    assert property (tk && cmd.instr == 8'h83 |=> progReset
      && accu == 0 && xReg == 0)
      else $error("reset wrong");
endmodule : axo_core_props
bind axo_core axo_core_props props_u (.mclk, .sys_rst, .cmdValid, .cmdReady,
  .cmd, .progRunning, .progHalt, .progReset, .paramWrite, .param, .accu, .xReg);
`default_nettype wire

// *** axo_host_model.sv ***
// Host model: offers one command frame at a time, waits for the reply.
// Assumes the cmdReady / replyValid handshake on mclk.
`timescale 1ns/1ps
`default_nettype none
module axo_host_model
  import axo_pkg::*;
(
  input wire logic mclk,
  input wire logic cmdReady,
  input wire logic replyValid,
  output var logic cmdValid,
  output var axo_cmd_t cmd
);
  // Idle at power-up
  initial begin
    cmdValid = 1'b0;
    cmd = '0;
  end
  // Idle frame bits are inverted so stale values never pass
  task automatic send(input axo_cmd_t c, input int read_axis_param_instr, output bit ok);
    int n;
    ok = 1'b0;
    repeat (read_axis_param_instr + 1) @(posedge mclk);
    cmdValid <= 1'b1;
    cmd <= c;
    for (n = 0; n < 60; n++) begin
      @(posedge mclk);
      if (cmdReady === 1'b1) break;
    end
    cmdValid <= 1'b0;
    cmd <= ~c;
    for (n = 0; n < 60; n++) begin
      #1;
      if (replyValid === 1'b1) begin
        ok = 1'b1;
        break;
      end
      @(posedge mclk);
    end
  endtask : send
endmodule : axo_host_model
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for axo_core.
// Assumes axo_host_model offers frames; bench drives accuLoad.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import axo_pkg::*;
  logic mclk, sys_rst, accuLoad, progRunning, cmdValid, cmdReady, replyValid;
  logic progHalt, progReset, paramWrite, targetPosWrite;
  logic [31:0] accuLoadValue, targetPos, accu, xReg;
  logic [7:0] targetPosMotor;
  axo_cmd_t cmd;
  axo_reply_t reply;
  axo_pwrite_t param;
  int failures = 0;
  int cmp_count = 0;
  axo_core dut_u (.mclk, .sys_rst, .cmdValid, .cmd, .accuLoad,
    .accuLoadValue, .progRunning, .cmdReady, .replyValid, .reply, .progHalt,
    .progReset, .paramWrite, .param, .targetPosWrite, .targetPosMotor,
    .targetPos, .accu, .xReg);
  axo_host_model host_u (.mclk, .cmdReady, .replyValid, .cmdValid, .cmd);
  // 10 MHz clock
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task end_of_test;
    $display("checks %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  task chk(input string n, input logic [63:0] s, input logic [63:0] e);
    cmp_count++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // Varying gap makes the host both prompt and slow
  task go(input logic [7:0] i, t, m, input logic [31:0] v);
    bit ok;
    host_u.send({i, t, m, v}, cmp_count % 3, ok);
    if (!ok) begin
      failures++;
      end_of_test;
    end
  endtask : go
  task ld(input logic [31:0] v);
    @(posedge mclk);
    accuLoad <= 1'b1;
    accuLoadValue <= v;
    @(posedge mclk);
    accuLoad <= 1'b0;
    accuLoadValue <= ~v;
  endtask : ld
  // X is only reachable through the copy or swap operation
  task setv(input logic [31:0] a, x);
    ld(x);
    go(8'h21, 8'h09, 8'h00, 32'h0);
    ld(a);
  endtask : setv
  // Expected {accu, xReg}; signed division truncates toward zero
  function logic [63:0] accu_immediate_instr_a(input int t, input logic [31:0] a, x);
    case (t)
      0: return {a + x, x};
      1: return {a - x, x};
      2: return {a * x, x};
      3: return {$signed(a) / $signed(x), x};
      4: return {$signed(a) % $signed(x), x};
      5: return {a & x, x};
      6: return {a | x, x};
      7: return {a ^ x, x};
      8: return {a, ~x};
      9: return {a, a};
      default: return {x, a};
    endcase
  endfunction : accu_immediate_instr_a
  task t_accu_immediate_instr_a;
    logic [63:0] ex;
    for (int t = 0; t < 11; t++) begin
      setv(32'hfffffff3, 32'h00000005);
      go(8'h21, t[7:0], 8'h00, 32'h0);
      ex = accu_immediate_instr_a(t, 32'hfffffff3, 32'h00000005);
      chk("accu", accu, ex[63:32]);
      chk("x reg", xReg, ex[31:0]);
      chk("status", reply.status, 8'h64);
    end
    go(8'h21, 8'h0b, 8'h00, 32'h0);
    chk("bad type", reply.status, 8'h03);
    setv(32'h00000007, 32'h0);
    go(8'h21, 8'h03, 8'h00, 32'h0);
    chk("div zero", reply.status, 8'h04);
    chk("div zero regs", {accu, xReg}, 64'h00000007_00000000);
    go(8'h21, 8'h04, 8'h00, 32'h0);
    chk("mod zero", reply.status, 8'h04);
    chk("mod zero regs", {accu, xReg}, 64'h00000007_00000000);
    $display("test accu_immediate_instr_a done");
  endtask : t_accu_immediate_instr_a
  task t_halt;
    @(posedge mclk);
    progRunning <= 1'b1;
    go(8'h1c, 8'h5a, 8'h03, 32'h12345678);
    chk("halt", {progHalt, reply.status}, {1'b1, 8'h64});
    @(posedge mclk);
    progRunning <= 1'b0;
    // Nothing running: no halt strobe, but the reply is still OK
    go(8'h1c, 8'h00, 8'h00, 32'h0);
    chk("no halt", {progHalt, reply.status}, {1'b0, 8'h64});
    $display("test halt done");
  endtask : t_halt
  task t_param;
    logic [7:0] bk [3];
    logic [31:0] av;
    bk = '{8'h00, 8'h02, 8'h03};
    av = 32'h80000001;
    ld(av);
    go(8'h22, 8'h00, 8'h03, 32'hdeadbeef);
    chk("axis", {paramWrite, param}, {2'b10, 16'h0003, av});
    chk("target", {targetPosWrite, targetPosMotor}, 9'h103);
    chk("target pos", targetPos, av);
    go(8'h22, 8'h05, 8'h01, 32'h0);
    chk("axis 5", {paramWrite, param}, {2'b10, 16'h0501, av});
    chk("no target", targetPosWrite, 1'b0);
    foreach (bk[b]) begin
      go(8'h23, 8'h2a, bk[b], 32'h0);
      chk("global", {paramWrite, param}, {2'b11, 8'h2a, bk[b], av});
      chk("bank", param.motorBank, bk[b]);
    end
    go(8'h23, 8'h2a, 8'h01, 32'h0);
    chk("bad bank", {paramWrite, reply.status}, {1'b0, 8'h04});
    $display("test param done");
  endtask : t_param
  task t_reset;
    setv(32'h5, 32'h9);
    go(8'h83, 8'h00, 8'h00, 32'h0);
    chk("reset pulse", progReset, 1'b1);
    chk("reset regs", {accu, xReg}, 64'h0);
    $display("test reset done");
  endtask : t_reset
  // Main sequence
  initial begin
    sys_rst = 1'b1;
    accuLoad = 1'b0;
    accuLoadValue = '0;
    progRunning = 1'b0;
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    t_accu_immediate_instr_a;
    t_halt;
    t_param;
    t_reset;
    end_of_test;
  end
endmodule : testbench
`default_nettype wire
